// ===== design/cdu_pkg.sv
// Constants and carrier types for the configuration download and update block.
// Assumes one 40 MHz clock and a host-side bus engine that presents decoded accesses.
package cdu_pkg;
    localparam int CDU_ADDR_W = 16;
    localparam int CDU_DATA_W = 8;
    localparam int CDU_CFG_DEPTH = 224;
    localparam int CDU_IDX_W = 8;
    localparam int CDU_CLK_HZ = 40000000;
    localparam real CDU_SE_DELAY_MS = 0.5;
    localparam int CDU_SE_DELAY_CYC = int'(CDU_SE_DELAY_MS * CDU_CLK_HZ / 1000.0);
    localparam int CDU_CNT_W = 16;
    localparam logic [CDU_ADDR_W-1:0] CDU_UPD_CTRL_ADDR = 16'h0090;
    localparam logic [CDU_ADDR_W-1:0] CDU_RELOAD_ADDR = 16'h00D8;
    localparam logic [CDU_ADDR_W-1:0] CDU_NV_BASE = 16'hF800;
    localparam logic [CDU_ADDR_W-1:0] CDU_NV_LAST = 16'hF8DF;
    localparam int CDU_BIT_TRANSP = 0;
    localparam int CDU_BIT_COMMIT = 1;
    localparam int CDU_BIT_ERASE_EN = 2;
    localparam int CDU_BIT_RELOAD = 0;
    localparam logic [CDU_DATA_W-1:0] CDU_UPD_RESET = 8'h00;
    localparam logic [CDU_DATA_W-1:0] CDU_UPD_WMASK = 8'h05;
    localparam logic [CDU_DATA_W-1:0] CDU_ERASED = 8'hFF;
    localparam logic [CDU_DATA_W-1:0] CDU_ZERO = 8'h00;
    localparam logic [CDU_IDX_W-1:0] CDU_PAGE_MASK = 8'hE0;

    typedef enum logic [1:0] {
        CDU_OP_NONE,
        CDU_OP_WRITE,
        CDU_OP_READ,
        CDU_OP_ERASE
    } cdu_op_t;

    typedef struct packed {
        cdu_op_t op;
        logic [CDU_ADDR_W-1:0] addr;
        logic [CDU_DATA_W-1:0] wdata;
    } cdu_req_t;

    typedef struct packed {
        logic ack;
        logic nack;
        logic [CDU_DATA_W-1:0] rdata;
    } cdu_rsp_t;
endpackage

// ===== design/cdu_loader.sv
// Configuration latches, nonvolatile image, download sequencer and update control.
// Assumes the bus engine issues one-cycle requests and ignores answers except one cycle later.
// Contract
// - Each configuration byte has a first-stage and an active latch.
// - Whole configuration is restored from nonvolatile memory on every power-up.
// - Download starts only after undervoltage lockout is released.
// - Fill all first stages, then copy all to active latches at once.
// - Wait 0.5 ms after download, then start the state step machine.
// - Any bus access before download completes is not acknowledged.
// - Transparent bit set: configuration writes reach both latch stages immediately unless a commit copy runs in the same cycle.
// - Transparent bit clear: writes change only the first-stage latch.
// - Writing commit bit copies every first stage into its active latch.
// - Nonvolatile edits leave the volatile latches unchanged.
// - Reload command restores nonvolatile contents, discarding latch edits.
// - Page erase acts only when erase-enable is set; sets page to ones.
// - Reload bit in user reload register reloads pages 0 to 6.
// - Host access restricted throughout the power-up download.
module cdu_loader
    import cdu_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic undervoltage_lockout_release,
    input wire cdu_req_t req,
    output cdu_rsp_t rsp,
    output logic download_done,
    output logic se_start,
    output logic [CDU_DATA_W-1:0] config_update_control,
    output logic [CDU_DATA_W*CDU_CFG_DEPTH-1:0] active_cfg
);
    typedef enum logic [2:0] {S_LOCKOUT, S_FILL, S_COMMIT, S_WAIT, S_RUN} cdu_state_t;

    logic [CDU_DATA_W-1:0] stage_r [CDU_CFG_DEPTH];
    logic [CDU_DATA_W-1:0] nv_r [CDU_CFG_DEPTH];
    logic [CDU_DATA_W*CDU_CFG_DEPTH-1:0] active_r;
    cdu_state_t state_r, state_nxt;
    logic [CDU_IDX_W-1:0] idx_r, idx_nxt;
    logic [CDU_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CDU_DATA_W-1:0] upd_r, upd_nxt;
    logic commit_r, commit_nxt;
    logic done_r, done_nxt;
    logic se_r, se_nxt;
    cdu_rsp_t rsp_r, rsp_nxt;

    logic is_cfg, is_nv, wr_cfg, wr_nv, er_nv, reload_cmd, pending_reload;
    logic [CDU_IDX_W-1:0] cfg_idx, nv_idx;
    logic hit0;

    assign cfg_idx = req.addr[CDU_IDX_W-1:0];
    assign nv_idx = req.addr[CDU_IDX_W-1:0];
    assign hit0 = wr_cfg && cfg_idx == '0;
    assign is_cfg = (req.addr < CDU_ADDR_W'(CDU_CFG_DEPTH)) && (req.addr != CDU_UPD_CTRL_ADDR)
        && (req.addr != CDU_RELOAD_ADDR);
    assign is_nv = (req.addr >= CDU_NV_BASE) && (req.addr <= CDU_NV_LAST);
    assign wr_cfg = done_r && req.op == CDU_OP_WRITE && is_cfg;
    assign wr_nv = done_r && req.op == CDU_OP_WRITE && is_nv;
    assign er_nv = done_r && req.op == CDU_OP_ERASE && is_nv && upd_r[CDU_BIT_ERASE_EN];
    assign reload_cmd = done_r && req.op == CDU_OP_WRITE && req.addr == CDU_RELOAD_ADDR
        && req.wdata[CDU_BIT_RELOAD];
    assign pending_reload = reload_cmd;

    // Download sequencer and control register
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        upd_nxt = upd_r;
        commit_nxt = 1'b0;
        done_nxt = done_r;
        se_nxt = se_r;
        rsp_nxt = '{ack: 1'b0, nack: 1'b0, rdata: CDU_ZERO};
        case (state_r)
            S_LOCKOUT: begin
                if (undervoltage_lockout_release) begin
                    state_nxt = S_FILL;
                    idx_nxt = '0;
                end
            end
            S_FILL: begin
                idx_nxt = idx_r + 1'b1;
                if (idx_r == CDU_IDX_W'(CDU_CFG_DEPTH - 1)) begin
                    state_nxt = S_COMMIT;
                end
            end
            S_COMMIT: begin
                done_nxt = 1'b1;
                if (se_r) begin
                    state_nxt = S_RUN;
                end else begin
                    state_nxt = S_WAIT;
                    cnt_nxt = '0;
                end
            end
            S_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (pending_reload) begin
                    state_nxt = S_FILL;
                    idx_nxt = '0;
                    done_nxt = 1'b0;
                end else if (cnt_r == CDU_CNT_W'(CDU_SE_DELAY_CYC - 1)) begin
                    se_nxt = 1'b1;
                    state_nxt = S_RUN;
                end
            end
            S_RUN: begin
                if (pending_reload) begin
                    state_nxt = S_FILL;
                    idx_nxt = '0;
                    done_nxt = 1'b0;
                end
            end
            default: state_nxt = S_LOCKOUT;
        endcase
        if (req.op != CDU_OP_NONE) begin
            if (!done_r) begin
                rsp_nxt.nack = 1'b1;
            end else begin
                rsp_nxt.ack = 1'b1;
                if (req.op == CDU_OP_READ) begin
                    if (req.addr == CDU_UPD_CTRL_ADDR) begin
                        rsp_nxt.rdata = upd_r;
                    end else if (is_cfg) begin
                        rsp_nxt.rdata = stage_r[cfg_idx];
                    end else if (is_nv) begin
                        rsp_nxt.rdata = nv_r[nv_idx];
                    end
                end
                if (req.op == CDU_OP_WRITE && req.addr == CDU_UPD_CTRL_ADDR) begin
                    upd_nxt = req.wdata & CDU_UPD_WMASK;
                    commit_nxt = req.wdata[CDU_BIT_COMMIT];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_LOCKOUT;
            idx_r <= '0;
            cnt_r <= '0;
            upd_r <= CDU_UPD_RESET;
            commit_r <= 1'b0;
            done_r <= 1'b0;
            se_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            upd_r <= upd_nxt;
            commit_r <= commit_nxt;
            done_r <= done_nxt;
            se_r <= se_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // Per-byte double-buffered latches and nonvolatile image
    for (genvar g = 0; g < CDU_CFG_DEPTH; g++) begin : g_lat
        logic [CDU_DATA_W-1:0] st_nxt, act_nxt, nv_nxt;
        logic hit_cfg, hit_nv, hit_page;
        assign hit_cfg = wr_cfg && cfg_idx == CDU_IDX_W'(g);
        assign hit_nv = wr_nv && nv_idx == CDU_IDX_W'(g);
        assign hit_page = er_nv && (nv_idx & CDU_PAGE_MASK) == (CDU_IDX_W'(g) & CDU_PAGE_MASK);
        always_comb begin
            st_nxt = stage_r[g];
            act_nxt = active_r[g*CDU_DATA_W +: CDU_DATA_W];
            nv_nxt = nv_r[g];
            if (state_r == S_FILL && idx_r == CDU_IDX_W'(g)) begin
                st_nxt = nv_r[g];
            end else if (hit_cfg) begin
                st_nxt = req.wdata;
                if (upd_r[CDU_BIT_TRANSP]) begin
                    act_nxt = req.wdata;
                end
            end
            if (state_r == S_COMMIT || commit_r) begin
                act_nxt = stage_r[g];
            end
            if (hit_page) begin
                nv_nxt = CDU_ERASED;
            end else if (hit_nv) begin
                nv_nxt = nv_r[g] & req.wdata;
            end
        end
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                stage_r[g] <= CDU_ZERO;
                active_r[g*CDU_DATA_W +: CDU_DATA_W] <= CDU_ZERO;
            end else begin
                stage_r[g] <= st_nxt;
                active_r[g*CDU_DATA_W +: CDU_DATA_W] <= act_nxt;
            end
        end
        always_ff @(posedge clk) begin
            nv_r[g] <= nv_nxt;
        end
    end

    assign rsp = rsp_r;
    assign download_done = done_r;
    assign se_start = se_r;
    assign config_update_control = upd_r;
    assign active_cfg = active_r;

    property p_nack_early;
        @(posedge clk) disable iff (!resetn)
        (req.op != CDU_OP_NONE && !done_r) |=> (rsp.nack && !rsp.ack);
    endproperty
    a_nack_early: assert property (p_nack_early) else $error("access not refused");

    property p_lockout;
        @(posedge clk) disable iff (!resetn)
        (state_r == S_LOCKOUT && !undervoltage_lockout_release) |=> state_r == S_LOCKOUT;
    endproperty
    a_lockout: assert property (p_lockout) else $error("download left lockout");

    sequence s_fill_end;
        state_r == S_FILL && idx_r == CDU_IDX_W'(CDU_CFG_DEPTH - 1);
    endsequence
    property p_fill_then_done;
        @(posedge clk) disable iff (!resetn) s_fill_end |=> ##1 download_done;
    endproperty
    a_fill_then_done: assert property (p_fill_then_done) else $error("no done");

    property p_se_delay;
        @(posedge clk) disable iff (!resetn)
        $rose(download_done) && !se_start |-> !se_start [*8];
    endproperty
    a_se_delay: assert property (p_se_delay) else $error("engine started early");

    property p_commit_read0;
        @(posedge clk) disable iff (!resetn) config_update_control[CDU_BIT_COMMIT] == 1'b0;
    endproperty
    a_commit_read0: assert property (p_commit_read0) else $error("commit bit stuck");

    property p_commit_copy;
        @(posedge clk) disable iff (!resetn)
        commit_r |=> active_r[CDU_DATA_W-1:0] == $past(stage_r[0]);
    endproperty
    a_commit_copy: assert property (p_commit_copy) else $error("commit missed");

    property p_staged;
        @(posedge clk) disable iff (!resetn)
        (hit0 && !upd_r[CDU_BIT_TRANSP] && !commit_r && done_r)
            |=> active_r[CDU_DATA_W-1:0] == $past(active_r[CDU_DATA_W-1:0]);
    endproperty
    a_staged: assert property (p_staged) else $error("staged write leaked");

    property p_transp;
        @(posedge clk) disable iff (!resetn)
        (hit0 && upd_r[CDU_BIT_TRANSP] && !commit_r && done_r)
            |=> active_r[CDU_DATA_W-1:0] == $past(req.wdata);
    endproperty
    a_transp: assert property (p_transp) else $error("write not immediate");

    property p_erase_gate;
        @(posedge clk) disable iff (!resetn)
        (req.op == CDU_OP_ERASE && !upd_r[CDU_BIT_ERASE_EN] && !wr_nv)
            |=> nv_r[0] == $past(nv_r[0]);
    endproperty
    a_erase_gate: assert property (p_erase_gate) else $error("erase not gated");
endmodule

// ===== testbench/cdu_host_model.sv
// Host bus master model driving decoded accesses into the loader.
// Assumes the loader answers each request within three clock edges.
module cdu_host_model
    import cdu_pkg::*;
(
    input wire logic clk,
    output cdu_req_t req,
    input wire cdu_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req = '{CDU_OP_NONE, 16'h0000, 8'h00};

    // One request for one cycle, then a bounded wait for the answer
    task automatic access(input cdu_op_t op, input logic [CDU_ADDR_W-1:0] a,
            input logic [CDU_DATA_W-1:0] d, output logic ack, output logic nack,
            output logic [CDU_DATA_W-1:0] rd);
        ack = 1'b0;
        nack = 1'b0;
        rd = 8'h00;
        @(posedge clk);
        #1 req = '{op, a, d};
        @(posedge clk);
        #1 req = '{CDU_OP_NONE, ~a, ~d};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            if (rsp.ack === 1'b1 || rsp.nack === 1'b1) begin
                ack = rsp.ack;
                nack = rsp.nack;
                rd = rsp.rdata;
                break;
            end
        end
    endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the configuration loader.
// Assumes the host model in cdu_host_model.sv and a 40 MHz clock.
module tb_top
    import cdu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        cdu_op_t op;
        logic [15:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [7:0] idx;
        logic [7:0] byt;
    } cdu_tb_row_t;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic lockout_rel = 1'b0;
    cdu_req_t req;
    cdu_rsp_t rsp;
    logic done;
    logic seq_start;
    logic [CDU_DATA_W*CDU_CFG_DEPTH-1:0] act;
    logic [7:0] upd;
    logic ack_s;
    logic nack_s;
    logic [7:0] rd_s;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    cdu_tb_row_t rows [14] = '{
        '{CDU_OP_WRITE, 16'h0090, 8'h00, 8'h00, 8'h05, 8'h5A},
        '{CDU_OP_WRITE, 16'h0005, 8'h3C, 8'h00, 8'h05, 8'h5A},
        '{CDU_OP_WRITE, 16'h0000, 8'h11, 8'h00, 8'h00, 8'hFF},
        '{CDU_OP_READ, 16'h0090, 8'h00, 8'h00, 8'h05, 8'h5A},
        '{CDU_OP_WRITE, 16'h0090, 8'h02, 8'h00, 8'h05, 8'h3C},
        '{CDU_OP_READ, 16'h0090, 8'h00, 8'h00, 8'h05, 8'h3C},
        '{CDU_OP_WRITE, 16'h0090, 8'h01, 8'h00, 8'h05, 8'h3C},
        '{CDU_OP_WRITE, 16'h0006, 8'h77, 8'h00, 8'h06, 8'h77},
        '{CDU_OP_WRITE, 16'h0000, 8'h22, 8'h00, 8'h00, 8'h22},
        '{CDU_OP_WRITE, 16'hF806, 8'h00, 8'h00, 8'h06, 8'h77},
        '{CDU_OP_WRITE, 16'h0090, 8'h00, 8'h00, 8'h06, 8'h77},
        '{CDU_OP_ERASE, 16'hF800, 8'h00, 8'h00, 8'h06, 8'h77},
        '{CDU_OP_WRITE, 16'h00D8, 8'h01, 8'h00, 8'h06, 8'h00},
        '{CDU_OP_READ, 16'h8000, 8'h00, 8'h00, 8'h05, 8'h5A}
    };

    always #12.5 clk = ~clk;

    cdu_host_model i_host (.clk(clk), .req(req), .rsp(rsp));

    cdu_loader i_dut (.clk(clk), .resetn(resetn), .undervoltage_lockout_release(lockout_rel),
        .req(req), .rsp(rsp), .download_done(done), .se_start(seq_start),
        .config_update_control(upd), .active_cfg(act));

    task automatic summarize();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic go(input cdu_op_t op, input logic [15:0] a, input logic [7:0] d);
        i_host.access(op, a, d, ack_s, nack_s, rd_s);
    endtask

    // Bounded wait for the download to finish, counting edges
    task automatic wait_done(output int k);
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("download_done", 8'h01, {7'h00, done});
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        go(CDU_OP_READ, CDU_UPD_CTRL_ADDR, 8'h00);
        check("early_nack", 8'h01, {7'h00, nack_s});
        repeat (300) @(posedge clk);
        #1 check("held_in_lockout", 8'h00, {7'h00, done});
        lockout_rel = 1'b1;
        wait_done(n);
        check("fill_long", 8'h01, 8'(n >= CDU_CFG_DEPTH));
        go(CDU_OP_WRITE, CDU_UPD_CTRL_ADDR, 8'h04);
        check("update_control", 8'h04, upd);
        for (int p = 0; p < 7; p++) go(CDU_OP_ERASE, CDU_NV_BASE + 16'(32 * p), 8'h00);
        go(CDU_OP_WRITE, CDU_NV_BASE + 16'h0005, 8'h5A);
        go(CDU_OP_WRITE, CDU_RELOAD_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        wait_done(n);
        check("erased_page", 8'hFF, act[8*200 +: 8]);
        foreach (rows[i]) begin
            go(rows[i].op, rows[i].addr, rows[i].wd);
            repeat (2) @(posedge clk);
            wait_done(n);
            check("ack", 8'h01, {7'h00, ack_s});
            if (rows[i].op == CDU_OP_READ) check("rdata", rows[i].rd, rd_s);
            check("active_byte", rows[i].byt, act[8*rows[i].idx +: 8]);
        end
        go(CDU_OP_WRITE, CDU_RELOAD_ADDR, 8'h01);
        go(CDU_OP_READ, CDU_UPD_CTRL_ADDR, 8'h00);
        check("reload_nack", 8'h01, {7'h00, nack_s});
        wait_done(n);
        resetn = 1'b0;
        repeat (6) @(posedge clk);
        #1 check("reset_done", 8'h00, {7'h00, done});
        resetn = 1'b1;
        wait_done(n);
        check("restored", 8'h5A, act[8*5 +: 8]);
        n = 0;
        while (seq_start !== 1'b1 && n < 21000) begin
            @(posedge clk);
            #1;
            n++;
        end
        total_checks++;
        if (n != CDU_SE_DELAY_CYC) begin
            mismatches++;
            $display("mismatch start_delay expected %0d seen %0d", CDU_SE_DELAY_CYC, n);
        end
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
